// [aio_pkg.sv]
// Shared constants and types for the board control register block.
// Assumes a single 100 MHz system clock and the local register port below.
package aio_pkg;

  localparam logic [6:0]  BOARD_CONTROL_OFS = 7'h00;
  localparam logic [31:0] BOARD_CONTROL_RST = 32'h2202_00A0;

  localparam int SRC_LSB        = 0;
  localparam int UNDERFLOW_BIT  = 3;
  localparam int RANGE_A_LSB    = 4;
  localparam int RANGE_B_LSB    = 6;
  localparam int SW_IN_CLK_BIT  = 8;
  localparam int BURST_EN_BIT   = 9;
  localparam int BURST_BUSY_BIT = 10;
  localparam int SW_IN_TRIG_BIT = 11;
  localparam int BUF_EN_BIT     = 12;
  localparam int BUF_CLR_BIT    = 13;
  localparam int THRESH_BIT     = 14;
  localparam int OVERFLOW_BIT   = 15;
  localparam int OUT_RANGE_LSB  = 16;
  localparam int SIMUL_BIT      = 18;
  localparam int BUF_OUT_BIT    = 19;
  localparam int SW_OUT_CLK_BIT = 20;
  localparam int TRIG_INIT_BIT  = 21;
  localparam int RATE_C_EN_BIT  = 22;
  localparam int CLK_INIT_BIT   = 24;
  localparam int OFFSET_BIN_BIT = 25;
  localparam int RATE_A_EN_BIT  = 26;
  localparam int RATE_B_EN_BIT  = 27;
  localparam int CAL_BIT        = 28;
  localparam int CAL_PASS_BIT   = 29;
  localparam int INIT_BIT       = 31;

  localparam int SYNC_STAGES    = 3;
  localparam int COUNT_W        = 19;

  typedef enum logic [2:0]
  {
    SRC_DIFF   = 3'h0,
    SRC_SINGLE = 3'h1,
    SRC_ZERO   = 3'h2,
    SRC_VREF   = 3'h3,
    SRC_OUT0   = 3'h4,
    SRC_OUT1   = 3'h5,
    SRC_RSVD6  = 3'h6,
    SRC_RSVD7  = 3'h7
  } aio_src_e;

  typedef enum logic [1:0]
  {
    RANGE_2V5  = 2'h0,
    RANGE_5V   = 2'h1,
    RANGE_10V  = 2'h2,
    RANGE_RSVD = 2'h3
  } aio_range_e;

  typedef enum logic [1:0]
  {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01
  } aio_cal_e;

  localparam aio_src_e   SRC_RST        = SRC_DIFF;
  localparam aio_range_e RANGE_RST      = RANGE_10V;
  localparam logic       OFFSET_BIN_RST = 1'b1;
  localparam logic       CAL_PASS_RST   = 1'b1;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [31:0] wdata;
  } aio_bus_req_s;

  typedef struct packed
  {
    aio_src_e   inputSourceSelect;
    aio_range_e rangeA;
    aio_range_e rangeB;
    aio_range_e outRange;
    logic       burstEn;
    logic       bufAcceptEn;
    logic       simultaneous;
    logic       bufferedOut;
    logic       trigInit;
    logic       clkInit;
    logic       offsetBinary;
    logic       rateAEn;
    logic       rateBEn;
    logic       rateCEn;
  } aio_cfg_s;

  localparam aio_cfg_s CFG_RST = '{
    inputSourceSelect: SRC_RST,
    rangeA:            RANGE_RST,
    rangeB:            RANGE_RST,
    outRange:          RANGE_RST,
    burstEn:           1'b0,
    bufAcceptEn:       1'b0,
    simultaneous:      1'b0,
    bufferedOut:       1'b0,
    trigInit:          1'b0,
    clkInit:           1'b0,
    offsetBinary:      OFFSET_BIN_RST,
    rateAEn:           1'b0,
    rateBEn:           1'b0,
    rateCEn:           1'b0
  };

endpackage

// [aio_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
// Assumes the pin is asynchronous to clk_sys.
module aio_pin_sync
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);
  import aio_pkg::*;

  logic [SYNC_STAGES-1:0] stage_reg;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      stage_reg <= '0;
    else
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], pinIn};
  end

  // A change counts only once the second and third stages agree
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      level <= 1'b0;
      rise  <= 1'b0;
    end
    else
    begin
      rise <= 1'b0;
      if (stage_reg[1] == stage_reg[2])
      begin
        level <= stage_reg[1];
        rise  <= stage_reg[1] & ~level;
      end
    end
  end

endmodule // aio_pin_sync

// [aio_board_control.sv]
// Board control and status register with its strobes, pin directions and flags.
// Assumes the local controller presents single-cycle read and write requests.
module aio_board_control
(
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  input  wire aio_pkg::aio_bus_req_s        busReq,
  output logic [31:0]                       regRdData,
  output logic                              regRdValid,
  input  wire logic                         underflowEvt,
  input  wire logic                         overflowEvt,
  input  wire logic [aio_pkg::COUNT_W-1:0]  bufCount,
  input  wire logic [aio_pkg::COUNT_W-1:0]  bufThreshold,
  input  wire logic                         burstDone,
  input  wire logic                         calDone,
  input  wire logic                         calFail,
  input  wire logic                         rateATick,
  input  wire logic                         rateBTick,
  input  wire logic                         rateCTick,
  input  wire logic                         trigPinI,
  output logic                              trigPinO,
  output logic                              trigPinOe,
  input  wire logic                         clkPinI,
  output logic                              clkPinO,
  output logic                              clkPinOe,
  output aio_pkg::aio_cfg_s                 cfg,
  output logic                              sampleStrobe,
  output logic                              burstStart,
  output logic                              burstBusy,
  output logic                              clearBuf,
  output logic                              outClkStrobe,
  output logic                              calStart,
  output logic                              calBusy,
  output logic                              boardInit
);
  import aio_pkg::*;

  aio_cfg_s   cfg_reg;
  aio_cal_e   calState_reg;
  logic       underflow_reg;
  logic       overflow_reg;
  logic       thresh_reg;
  logic       burstBusy_reg;
  logic       calPass_reg;
  logic       wrHit;
  logic       initHit;
  logic       actHit;
  logic       trigLevel;
  logic       trigRise;
  logic       clkLevel;
  logic       clkRise;
  logic       trigEvt;
  logic       burstGo;
  logic [31:0] image;

  // Reserved codes leave the field unchanged
  function automatic aio_range_e pickRange(logic [1:0] wr, aio_range_e cur);
    pickRange = (wr == RANGE_RSVD) ? cur : aio_range_e'(wr);
  endfunction

  function automatic logic wrBit(logic [31:0] d, int pos);
    wrBit = d[pos];
  endfunction

  aio_pin_sync u_trigSync
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (trigPinI),
    .level   (trigLevel),
    .rise    (trigRise)
  );

  aio_pin_sync u_clkSync
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (clkPinI),
    .level   (clkLevel),
    .rise    (clkRise)
  );

  assign wrHit   = busReq.wr && (busReq.addr == BOARD_CONTROL_OFS);
  assign initHit = wrHit && wrBit(busReq.wdata, INIT_BIT);
  assign actHit  = wrHit && !wrBit(busReq.wdata, INIT_BIT);

  // Configuration fields
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_reg <= CFG_RST;
    else if (initHit)
      cfg_reg <= CFG_RST;
    else if (actHit)
    begin
      if (busReq.wdata[SRC_LSB+2:SRC_LSB] < 3'(SRC_RSVD6))
        cfg_reg.inputSourceSelect <= aio_src_e'(busReq.wdata[SRC_LSB+2:SRC_LSB]);
      cfg_reg.rangeA <= pickRange(busReq.wdata[RANGE_A_LSB+1:RANGE_A_LSB],
                                  cfg_reg.rangeA);
      cfg_reg.rangeB <= pickRange(busReq.wdata[RANGE_B_LSB+1:RANGE_B_LSB],
                                  cfg_reg.rangeB);
      cfg_reg.outRange <= pickRange(busReq.wdata[OUT_RANGE_LSB+1:OUT_RANGE_LSB],
                                    cfg_reg.outRange);
      cfg_reg.burstEn      <= busReq.wdata[BURST_EN_BIT];
      cfg_reg.bufAcceptEn  <= busReq.wdata[BUF_EN_BIT];
      cfg_reg.simultaneous <= busReq.wdata[SIMUL_BIT];
      cfg_reg.bufferedOut  <= busReq.wdata[BUF_OUT_BIT];
      cfg_reg.trigInit     <= busReq.wdata[TRIG_INIT_BIT];
      cfg_reg.clkInit      <= busReq.wdata[CLK_INIT_BIT];
      cfg_reg.offsetBinary <= busReq.wdata[OFFSET_BIN_BIT];
      cfg_reg.rateAEn      <= busReq.wdata[RATE_A_EN_BIT];
      cfg_reg.rateBEn      <= busReq.wdata[RATE_B_EN_BIT];
      cfg_reg.rateCEn      <= busReq.wdata[RATE_C_EN_BIT];
    end
  end

  assign cfg = cfg_reg;

  // Sticky buffer error flags; a hardware event wins over a bus clear but not over an initialize write
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      underflow_reg <= 1'b0;
      overflow_reg  <= 1'b0;
    end
    else if (initHit)
    begin
      underflow_reg <= 1'b0;
      overflow_reg  <= 1'b0;
    end
    else
    begin
      underflow_reg <= underflowEvt |
                       (actHit ? busReq.wdata[UNDERFLOW_BIT] : underflow_reg);
      overflow_reg  <= overflowEvt |
                       (actHit ? busReq.wdata[OVERFLOW_BIT] : overflow_reg);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      thresh_reg <= 1'b0;
    else
      thresh_reg <= (bufCount > bufThreshold);
  end

  // Sample clock: software strobe forces a sample whatever the source
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sampleStrobe <= 1'b0;
      clkPinO      <= 1'b0;
    end
    else
    begin
      sampleStrobe <= (actHit && busReq.wdata[SW_IN_CLK_BIT]) ||
                      (cfg_reg.clkInit ? (cfg_reg.rateAEn && rateATick) : clkRise);
      clkPinO      <= cfg_reg.clkInit && cfg_reg.rateAEn && rateATick;
    end
  end

  assign clkPinOe  = cfg_reg.clkInit;
  assign trigPinOe = cfg_reg.trigInit;

  // Burst trigger: software trigger overrides the selected source
  assign trigEvt = (actHit && busReq.wdata[SW_IN_TRIG_BIT]) ||
                   (cfg_reg.trigInit ? (cfg_reg.rateBEn && rateBTick) : trigRise);
  assign burstGo = cfg_reg.burstEn && trigEvt && !burstBusy_reg;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      burstBusy_reg <= 1'b0;
      burstStart    <= 1'b0;
      trigPinO      <= 1'b0;
    end
    else
    begin
      burstStart <= burstGo && !initHit;
      trigPinO   <= cfg_reg.trigInit && trigEvt;
      if (initHit || !cfg_reg.burstEn || burstDone)
        burstBusy_reg <= 1'b0;
      else if (burstGo)
        burstBusy_reg <= 1'b1;
    end
  end

  assign burstBusy = burstBusy_reg;

  // Single-action pulses, plus the rate C tick on outClkStrobe, one cycle each
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clearBuf     <= 1'b0;
      outClkStrobe <= 1'b0;
      boardInit    <= 1'b0;
    end
    else
    begin
      clearBuf     <= actHit && busReq.wdata[BUF_CLR_BIT];
      outClkStrobe <= (actHit && busReq.wdata[SW_OUT_CLK_BIT]) ||
                      (cfg_reg.rateCEn && rateCTick);
      boardInit    <= initHit;
    end
  end

  // Autocalibration sequencing
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      calState_reg <= CAL_IDLE;
      calPass_reg  <= CAL_PASS_RST;
      calStart     <= 1'b0;
    end
    else
    begin
      calStart <= 1'b0;
      if (initHit)
      begin
        calState_reg <= CAL_IDLE;
        calPass_reg  <= CAL_PASS_RST;
      end
      else
      begin
        case (calState_reg)
          CAL_IDLE:
          begin
            if (actHit && busReq.wdata[CAL_BIT])
            begin
              calState_reg <= CAL_RUN;
              calPass_reg  <= 1'b1;
              calStart     <= 1'b1;
            end
          end
          CAL_RUN:
          begin
            if (calDone)
            begin
              calState_reg <= CAL_IDLE;
              if (calFail)
                calPass_reg <= 1'b0;
            end
          end
          default:
            calState_reg <= CAL_IDLE;
        endcase
      end
    end
  end

  assign calBusy = (calState_reg == CAL_RUN);

  // Read image; action bits except CAL, which reads calBusy, and out-of-scope bits read as zero
  always_comb
  begin
    image                                   = '0;
    image[SRC_LSB+2:SRC_LSB]                = cfg_reg.inputSourceSelect;
    image[UNDERFLOW_BIT]                    = underflow_reg;
    image[RANGE_A_LSB+1:RANGE_A_LSB]        = cfg_reg.rangeA;
    image[RANGE_B_LSB+1:RANGE_B_LSB]        = cfg_reg.rangeB;
    image[BURST_EN_BIT]                     = cfg_reg.burstEn;
    image[BURST_BUSY_BIT]                   = burstBusy_reg;
    image[BUF_EN_BIT]                       = cfg_reg.bufAcceptEn;
    image[THRESH_BIT]                       = thresh_reg;
    image[OVERFLOW_BIT]                     = overflow_reg;
    image[OUT_RANGE_LSB+1:OUT_RANGE_LSB]    = cfg_reg.outRange;
    image[SIMUL_BIT]                        = cfg_reg.simultaneous;
    image[BUF_OUT_BIT]                      = cfg_reg.bufferedOut;
    image[TRIG_INIT_BIT]                    = cfg_reg.trigInit;
    image[RATE_C_EN_BIT]                    = cfg_reg.rateCEn;
    image[CLK_INIT_BIT]                     = cfg_reg.clkInit;
    image[OFFSET_BIN_BIT]                   = cfg_reg.offsetBinary;
    image[RATE_A_EN_BIT]                    = cfg_reg.rateAEn;
    image[RATE_B_EN_BIT]                    = cfg_reg.rateBEn;
    image[CAL_BIT]                          = calBusy;
    image[CAL_PASS_BIT]                     = calPass_reg;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regRdData  <= '0;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= busReq.rd;
      if (busReq.rd)
        regRdData <= (busReq.addr == BOARD_CONTROL_OFS) ? image : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence swTrigTaken;
    actHit && busReq.wdata[SW_IN_TRIG_BIT] && cfg_reg.burstEn && !burstBusy_reg;
  endsequence

  sequence burstOpened;
    burstStart && burstBusy_reg;
  endsequence

  sequence calFailEnd;
    calState_reg == CAL_RUN && calDone && calFail && !initHit;
  endsequence

  a_src_reserved: assert property (
    actHit && busReq.wdata[2:0] > 3'h5 |=> $stable(cfg_reg.inputSourceSelect))
    else $error("reserved source code changed the field");

  a_underflow_sticky: assert property (
    underflowEvt && !initHit |=> underflow_reg)
    else $error("underflow event lost");

  a_overflow_sticky: assert property (
    overflow_reg && !initHit && !(actHit && !busReq.wdata[OVERFLOW_BIT]) |=> overflow_reg)
    else $error("overflow flag dropped without clear");

  a_range_a_write: assert property (
    actHit && busReq.wdata[5:4] != 2'h3 |=> cfg_reg.rangeA == $past(busReq.wdata[5:4]))
    else $error("range A not written");

  a_sw_sample: assert property (
    actHit && busReq.wdata[SW_IN_CLK_BIT] |=> sampleStrobe)
    else $error("software sample missing");

  a_sw_burst: assert property (
    swTrigTaken |=> burstOpened)
    else $error("software trigger did not open burst");

  a_clear_pulse: assert property (
    actHit && busReq.wdata[BUF_CLR_BIT]
    |=> clearBuf ##1 (clearBuf == $past(actHit && busReq.wdata[BUF_CLR_BIT])))
    else $error("clear pulse wrong");

  a_thresh_flag: assert property (
    (bufCount > bufThreshold) [*2] |-> thresh_reg)
    else $error("threshold flag low above threshold");

  a_sw_out_clock: assert property (
    actHit && busReq.wdata[SW_OUT_CLK_BIT] |=> outClkStrobe)
    else $error("software output clock missing");

  a_cal_start: assert property (
    calStart |-> calPass_reg && calBusy)
    else $error("calibration start without pass and busy");

  a_cal_fail: assert property (
    calFailEnd |=> !calBusy && !calPass_reg)
    else $error("failed calibration not reported");

  a_init_defaults: assert property (
    initHit |=> cfg_reg == CFG_RST && boardInit && calPass_reg ##1 !boardInit)
    else $error("initialize did not restore defaults");

endmodule // aio_board_control

// [aio_board_control_test.sv]
// Self-checking testbench for the board control register block.
// Assumes aio_pkg and aio_board_control are compiled first; assertions live in the design.
module aio_board_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import aio_pkg::*;

  logic                 clk_sys;
  logic                 sys_rst;
  aio_bus_req_s         busReq;
  logic [31:0]          regRdData;
  logic                 regRdValid;
  logic                 underflowEvt;
  logic                 overflowEvt;
  logic [COUNT_W-1:0]   bufCount;
  logic [COUNT_W-1:0]   bufThreshold;
  logic                 burstDone;
  logic                 calDone;
  logic                 calFail;
  logic                 rateATick;
  logic                 rateBTick;
  logic                 rateCTick;
  logic                 trigPinI;
  logic                 trigPinO;
  logic                 trigPinOe;
  logic                 clkPinI;
  logic                 clkPinO;
  logic                 clkPinOe;
  aio_cfg_s             cfg;
  logic                 sampleStrobe;
  logic                 burstStart;
  logic                 burstBusy;
  logic                 clearBuf;
  logic                 outClkStrobe;
  logic                 calStart;
  logic                 calBusy;
  logic                 boardInit;
  logic [7:0]           pulses;
  logic [31:0]          rdVal;
  int                   cnt;
  int                   cycles;
  int                   fail_count;
  int                   n_compared;

  assign pulses = {clkPinO, trigPinO, boardInit, calStart, outClkStrobe, clearBuf, burstStart,
                   sampleStrobe};

  aio_board_control aio_board_control_i
  (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .busReq       (busReq),
    .regRdData    (regRdData),
    .regRdValid   (regRdValid),
    .underflowEvt (underflowEvt),
    .overflowEvt  (overflowEvt),
    .bufCount     (bufCount),
    .bufThreshold (bufThreshold),
    .burstDone    (burstDone),
    .calDone      (calDone),
    .calFail      (calFail),
    .rateATick    (rateATick),
    .rateBTick    (rateBTick),
    .rateCTick    (rateCTick),
    .trigPinI     (trigPinI),
    .trigPinO     (trigPinO),
    .trigPinOe    (trigPinOe),
    .clkPinI      (clkPinI),
    .clkPinO      (clkPinO),
    .clkPinOe     (clkPinOe),
    .cfg          (cfg),
    .sampleStrobe (sampleStrobe),
    .burstStart   (burstStart),
    .burstBusy    (burstBusy),
    .clearBuf     (clearBuf),
    .outClkStrobe (outClkStrobe),
    .calStart     (calStart),
    .calBusy      (calBusy),
    .boardInit    (boardInit)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Counts highs of one strobe over four cycles and catches any read answer
  task automatic watch(input int idx);
    cnt   = 0;
    rdVal = 'x;
    repeat (4)
    begin
      if (idx >= 0 && pulses[idx] === 1'b1) cnt++;
      if (regRdValid === 1'b1) rdVal = regRdData;
      @(negedge clk_sys);
    end
  endtask

  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d, input int idx);
    @(negedge clk_sys);
    busReq.wr    = w;
    busReq.rd    = ~w;
    busReq.addr  = a;
    busReq.wdata = d;
    @(negedge clk_sys);
    busReq = '0;
    watch(idx);
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, -1);
    check("readback", rdVal, exp);
  endtask

  // One-cycle input pulse, then watch a strobe
  task automatic pulse_in(ref logic sig, input int idx);
    @(negedge clk_sys);
    sig = 1'b1;
    @(negedge clk_sys);
    sig = 1'b0;
    watch(idx);
  endtask

  task automatic t_reset();
    rd(7'h00, BOARD_CONTROL_RST);
    check("cfg", 32'(cfg), 32'(CFG_RST));
    check("pin enables", {30'h0, trigPinOe, clkPinOe}, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_fields();
    for (int s = 0; s < 6; s++)
    begin
      bus(1'b1, 7'h00, 32'h2202_00A0 | 32'(s), -1);
      rd(7'h00, 32'h2202_00A0 | 32'(s));
    end
    bus(1'b1, 7'h00, 32'h2202_00A6, -1);
    rd(7'h00, 32'h2202_00A5);
    bus(1'b1, 7'h00, 32'h2203_0041, -1);
    rd(7'h00, 32'h2202_0041);
    bus(1'b1, 7'h00, 32'h2202_0070, -1);
    rd(7'h00, 32'h2202_0040);
    for (int r = 0; r < 3; r++)
    begin
      bus(1'b1, 7'h00, 32'h0200_0000 | 32'(r << 16) | 32'(r << 6) | 32'(r << 4), -1);
      rd(7'h00, 32'h2200_0000 | 32'(r << 16) | 32'(r << 6) | 32'(r << 4));
    end
    $display("test fields done");
  endtask

  task automatic t_config();
    bus(1'b1, 7'h00, 32'h0FEC_1000, -1);
    rd(7'h00, 32'h2F6C_1000);
    check("cfg bits", {21'h0, cfg.bufAcceptEn, cfg.simultaneous, cfg.bufferedOut, cfg.trigInit,
          cfg.clkInit, cfg.offsetBinary, cfg.rateAEn, cfg.rateBEn, cfg.rateCEn, trigPinOe,
          clkPinOe}, 32'h0000_07FF);
    bus(1'b1, 7'h00, 32'h0000_0000, -1);
    check("cfg off", {22'h0, cfg.bufAcceptEn, cfg.offsetBinary, cfg.rateAEn, cfg.rateBEn,
          cfg.rateCEn, trigPinOe, clkPinOe, cfg.simultaneous, cfg.bufferedOut, cfg.clkInit},
          32'h0000_0000);
    bus(1'b1, 7'h00, 32'h0100_0000, -1);
    pulse_in(rateATick, 0);
    check("tick while disabled", 32'(cnt), 32'h0000_0000);
    bus(1'b1, 7'h00, 32'h0500_0000, -1);
    pulse_in(rateATick, 0);
    check("tick while enabled", 32'(cnt), 32'h0000_0001);
    pulse_in(rateATick, 7);
    check("clock pin out", 32'(cnt), 32'h0000_0001);
    $display("test config done");
  endtask

  task automatic t_actions();
    int bits [3] = '{8, 13, 20};
    int idxs [3] = '{0, 2, 3};
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, 7'h00, 32'h0000_0001 << bits[k], idxs[k]);
      check("action strobe", 32'(cnt), 32'h0000_0001);
      rd(7'h00, 32'h2000_0000);
    end
    bus(1'b1, 7'h00, 32'h0000_0200, -1);
    bus(1'b1, 7'h00, 32'h0000_0A00, 1);
    check("burst start", 32'(cnt), 32'h0000_0001);
    rd(7'h00, 32'h2000_0600);
    check("burst busy", 32'(burstBusy), 32'h0000_0001);
    bus(1'b1, 7'h00, 32'h0000_0A00, 1);
    check("retrigger while busy", 32'(cnt), 32'h0000_0000);
    pulse_in(burstDone, -1);
    rd(7'h00, 32'h2000_0200);
    $display("test actions done");
  endtask

  task automatic t_flags();
    bus(1'b1, 7'h00, 32'h0000_0000, -1);
    pulse_in(underflowEvt, -1);
    rd(7'h00, 32'h2000_0008);
    pulse_in(overflowEvt, -1);
    rd(7'h00, 32'h2000_8008);
    rd(7'h00, 32'h2000_8008);
    bus(1'b1, 7'h00, 32'h0000_8000, -1);
    rd(7'h00, 32'h2000_8000);
    bus(1'b1, 7'h00, 32'h0000_0000, -1);
    rd(7'h00, 32'h2000_0000);
    bufThreshold = 19'h0_0004;
    bufCount     = 19'h0_0005;
    rd(7'h00, 32'h2000_4000);
    bufCount = 19'h0_0004;
    bus(1'b1, 7'h00, 32'h0000_4000, -1);
    rd(7'h00, 32'h2000_0000);
    $display("test flags done");
  endtask

  task automatic t_cal();
    bus(1'b1, 7'h00, 32'h1000_0000, 4);
    check("cal start", 32'(cnt), 32'h0000_0001);
    check("cal busy", 32'(calBusy), 32'h0000_0001);
    rd(7'h00, 32'h3000_0000);
    bus(1'b1, 7'h00, 32'h1000_0000, 4);
    check("cal restart", 32'(cnt), 32'h0000_0000);
    calFail = 1'b1;
    pulse_in(calDone, -1);
    calFail = 1'b0;
    rd(7'h00, 32'h0000_0000);
    bus(1'b1, 7'h00, 32'h1000_0000, 4);
    rd(7'h00, 32'h3000_0000);
    pulse_in(calDone, -1);
    rd(7'h00, 32'h2000_0000);
    $display("test calibration done");
  endtask

  // Pin inputs pass the synchroniser; rate ticks drive the trigger pin and output clock
  task automatic t_pins();
    int seen;
    @(negedge clk_sys);
    clkPinI = 1'b1;
    watch(0);
    seen = cnt;
    watch(0);
    check("pin sample", 32'(seen + cnt), 32'h0000_0001);
    clkPinI = 1'b0;
    bus(1'b1, 7'h00, 32'h0000_0200, -1);
    trigPinI = 1'b1;
    watch(1);
    seen = cnt;
    watch(1);
    check("pin trigger", 32'(seen + cnt), 32'h0000_0001);
    trigPinI = 1'b0;
    pulse_in(burstDone, -1);
    bus(1'b1, 7'h00, 32'h0860_0200, -1);
    pulse_in(rateBTick, 6);
    check("trigger pin out", 32'(cnt), 32'h0000_0001);
    pulse_in(rateCTick, 3);
    check("rate C clock", 32'(cnt), 32'h0000_0001);
    $display("test pins done");
  endtask

  task automatic t_init();
    bus(1'b1, 7'h00, 32'h0FEC_1205, -1);
    pulse_in(overflowEvt, -1);
    bus(1'b1, 7'h00, 32'h8000_0001, 5);
    check("init strobe", 32'(cnt), 32'h0000_0001);
    rd(7'h00, BOARD_CONTROL_RST);
    check("cfg after init", 32'(cfg), 32'(CFG_RST));
    bus(1'b1, 7'h04, 32'hFFFF_FFFF, -1);
    rd(7'h04, 32'h0000_0000);
    rd(7'h00, BOARD_CONTROL_RST);
    $display("test init done");
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    sys_rst      = 1'b1;
    busReq       = '0;
    underflowEvt = 1'b0;
    overflowEvt  = 1'b0;
    bufCount     = '0;
    bufThreshold = '0;
    burstDone    = 1'b0;
    calDone      = 1'b0;
    calFail      = 1'b0;
    rateATick    = 1'b0;
    rateBTick    = 1'b0;
    rateCTick    = 1'b0;
    trigPinI     = 1'b0;
    clkPinI      = 1'b0;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_config();
    t_actions();
    t_flags();
    t_cal();
    t_pins();
    t_init();
    close_out();
  end
endmodule // aio_board_control_test
